// ==== hdl/lfs_fault_status.v ====
// Purpose: Fault status, masking and fault pin of the LED bypass matrix
// Assumes: Register strobes and event inputs are on ref_clk
// Notes:   Analog condition pins and the clock pin are synchronised here
//
// Notes on behaviour
// - Mask bit 6 gates serial error summary
// - Mask bit 5 gates open-trace summary
// - Mask bit 4 gates open-lamp summary
// - Mask bit 3 gates shorted-lamp summary
// - Mask bit 2 gates pump-not-ready flag
// - Shutdown closes switches, or opens if bit1
// - Mask bit 0 gates thermal warning
// - Any unmasked fault bit asserts fault pin
// - Bit 9 busy while configuration applies
// - Bit 8 high until grade readout done
// - Bit 7 flags slow selected external clock
// - Bit 6 is OR of serial errors
// - Bit 5 is OR of trace breaks
// - Bit 4 is OR of lamp opens
// - Bit 3 is OR of lamp shorts
// - Bit 2 mirrors charge pump not ready
// - Shutdown latches, read clears once gone
// - Warning latches, read clears once gone
// - Per-driver open flags latch, read clears
// - Serial error flags clear on read
// - Select codes 2 and 3 use clock pin
`timescale 1ns/100ps
`include "lfs_consts.vh"

module lfs_fault_status #(
    parameter EXT_MAX_PER_NS = `LFS_EXT_MAX_PER_NS
) (
    input  wire                     ref_clk,
    input  wire                     rst,
    input  wire [`LFS_ADDR_W-1:0]   reg_addr,
    input  wire                     reg_wr,
    input  wire                     reg_rd,
    input  wire [`LFS_DATA_W-1:0]   reg_wdata,
    output wire [`LFS_DATA_W-1:0]   reg_rdata,
    input  wire [`LFS_SER_N-1:0]    serial_err_event,
    input  wire                     serial_status_rd,
    output wire [`LFS_SER_N-1:0]    serial_err_flags,
    input  wire [`LFS_DRV_N-1:0]    per_driver_trace_break,
    input  wire [`LFS_DRV_N-1:0]    per_driver_lamp_shorted,
    input  wire [`LFS_DRV_N-1:0]    lamp_open_detect,
    input  wire                     pump_not_ready_pin,
    input  wire                     overtemp_shutdown_pin,
    input  wire                     overtemp_warning_pin,
    input  wire                     dimming_clk_pin,
    input  wire [`LFS_SEL_W-1:0]    clk_sel,
    input  wire                     general_config_write,
    input  wire                     config_applied,
    input  wire                     grade_done,
    input  wire [`LFS_GRADE_W-1:0]  grade_code_in,
    output wire [`LFS_GRADE_W-1:0]  rating_grade_code,
    output wire                     grade_read_pending,
    output wire                     config_pending,
    output wire                     switch_close_all,
    output wire                     switch_open_all,
    output wire                     fault_flag_n
);

    // ======================================================================
    // Timing
    localparam integer SLOW_CYCLES_RAW = EXT_MAX_PER_NS / `LFS_CLK_PERIOD_NS;
    localparam integer SLOW_CYCLES     = (SLOW_CYCLES_RAW < 1) ? 1 :
                                         SLOW_CYCLES_RAW;
    localparam [`LFS_MON_CNT_W-1:0] SLOW_LIMIT =
        SLOW_CYCLES[`LFS_MON_CNT_W-1:0];

    // ======================================================================
    // Declarations
    reg  [`LFS_MASK_W-1:0]  mask_reg;
    reg  [`LFS_DRV_N-1:0]   lamp_open_reg;
    reg  [`LFS_DRV_N-1:0]   lamp_open_next;
    reg  [`LFS_SER_N-1:0]   serial_err_reg;
    reg  [`LFS_SER_N-1:0]   serial_err_next;
    reg                     shdn_reg;
    reg                     shdn_next;
    reg                     warn_reg;
    reg                     warn_next;
    reg                     config_reg;
    reg                     grade_pend_reg;
    reg  [`LFS_GRADE_W-1:0] grade_reg;
    reg  [`LFS_DATA_W-1:0]  rdata_reg;
    reg  [`LFS_DATA_W-1:0]  rdata_next;
    reg                     fault_n_reg;
    reg                     close_reg;
    reg                     open_reg;
    reg  [`LFS_DATA_W-1:0]  status_word;
    reg  [`LFS_DATA_W-1:0]  mask_word;
    reg  [`LFS_DATA_W-1:0]  open_word;

    wire [2:0]              cond_sync;
    wire                    pump_nrdy;
    wire                    shdn_cond;
    wire                    warn_cond;
    wire                    clk_sync;
    wire                    ext_sel;
    wire                    ext_slow;
    wire                    mask_wr;
    wire                    stat_rd;
    wire                    open_rd;
    wire                    serial_sum;
    wire                    trace_sum;
    wire                    lamp_open_summary;
    wire                    lamp_shorted_summary;
    wire                    fault_any;

    wire mask_serial_error;
    wire mask_trace_break;
    wire mask_lamp_open;
    wire mask_lamp_shorted;
    wire mask_pump_not_ready;
    wire overtemp_switch_action;
    wire mask_overtemp_warning;

    // ======================================================================
    // Input synchronisers and clock monitor
    lfs_sync #(
        .W (3)
    ) u_cond_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d_in    ({pump_not_ready_pin, overtemp_shutdown_pin,
                   overtemp_warning_pin}),
        .q_out   (cond_sync)
    );

    assign pump_nrdy = cond_sync[2];
    assign shdn_cond = cond_sync[1];
    assign warn_cond = cond_sync[0];

    lfs_sync #(
        .W (1)
    ) u_clk_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d_in    (dimming_clk_pin),
        .q_out   (clk_sync)
    );

    assign ext_sel = clk_sel[`LFS_SEL_EXT_BIT];

    lfs_clk_monitor #(
        .LIMIT (SLOW_LIMIT)
    ) u_clk_mon (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .enable    (ext_sel),
        .clk_level (clk_sync),
        .slow      (ext_slow)
    );

    // ======================================================================
    // Register strobes
    assign mask_wr = reg_wr & (reg_addr == `LFS_ADDR_MASK);
    assign stat_rd = reg_rd & (reg_addr == `LFS_ADDR_STAT);
    assign open_rd = reg_rd & (reg_addr == `LFS_ADDR_OPEN);

    // ======================================================================
    // Mask register fields
    assign mask_serial_error      = mask_reg[`LFS_MSK_SERIAL];
    assign mask_trace_break       = mask_reg[`LFS_MSK_TRACE];
    assign mask_lamp_open         = mask_reg[`LFS_MSK_OPEN];
    assign mask_lamp_shorted      = mask_reg[`LFS_MSK_SHORT];
    assign mask_pump_not_ready    = mask_reg[`LFS_MSK_PUMP];
    assign overtemp_switch_action = mask_reg[`LFS_MSK_ACTION];
    assign mask_overtemp_warning  = mask_reg[`LFS_MSK_WARN];

    always @(posedge ref_clk) begin
        if (rst) begin
            mask_reg <= `LFS_MASK_RST;
        end else if (mask_wr) begin
            mask_reg <= reg_wdata[`LFS_MASK_W-1:0];
        end
    end

    // ======================================================================
    // Sticky flags: a set in the clearing cycle wins
    always @* begin
        serial_err_next = serial_err_reg;
        if (serial_status_rd) begin
            serial_err_next = `LFS_SER_ZERO;
        end
        serial_err_next = serial_err_next | serial_err_event;

        lamp_open_next = lamp_open_reg;
        if (open_rd) begin
            lamp_open_next = `LFS_DRV_ZERO;
        end
        lamp_open_next = lamp_open_next | lamp_open_detect;

        shdn_next = shdn_reg | shdn_cond;
        if (stat_rd && !shdn_cond) begin
            shdn_next = 1'b0;
        end

        warn_next = warn_reg | warn_cond;
        if (stat_rd && !warn_cond) begin
            warn_next = 1'b0;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            serial_err_reg <= `LFS_SER_ZERO;
            lamp_open_reg  <= `LFS_DRV_ZERO;
            shdn_reg       <= 1'b0;
            warn_reg       <= 1'b0;
        end else begin
            serial_err_reg <= serial_err_next;
            lamp_open_reg  <= lamp_open_next;
            shdn_reg       <= shdn_next;
            warn_reg       <= warn_next;
        end
    end

    // ======================================================================
    // Configuration busy and grade readout
    always @(posedge ref_clk) begin
        if (rst) begin
            config_reg     <= 1'b0;
            grade_pend_reg <= 1'b1;
            grade_reg      <= `LFS_GRADE_RST;
        end else begin
            if (general_config_write) begin
                config_reg <= 1'b1;
            end else if (config_applied) begin
                config_reg <= 1'b0;
            end
            if (grade_done) begin
                grade_pend_reg <= 1'b0;
                grade_reg      <= grade_code_in;
            end
        end
    end

    // ======================================================================
    // Summaries and status word
    assign serial_sum           = |serial_err_reg;
    assign trace_sum            = |per_driver_trace_break;
    assign lamp_open_summary    = |lamp_open_reg;
    assign lamp_shorted_summary = |per_driver_lamp_shorted;

    always @* begin
        status_word                = `LFS_DATA_ZERO;
        status_word[`LFS_ST_WARN]  = warn_reg;
        status_word[`LFS_ST_SHDN]  = shdn_reg;
        status_word[`LFS_ST_PUMP]  = pump_nrdy;
        status_word[`LFS_ST_SHORT] = lamp_shorted_summary;
        status_word[`LFS_ST_OPEN]  = lamp_open_summary;
        status_word[`LFS_ST_TRACE] = trace_sum;
        status_word[`LFS_ST_SERIAL] = serial_sum;
        status_word[`LFS_ST_EXTCLK] = ext_sel & ext_slow;
        status_word[`LFS_ST_GRADE] = grade_pend_reg;
        status_word[`LFS_ST_CONFIG] = config_reg;

        mask_word                  = `LFS_DATA_ZERO;
        mask_word[`LFS_MASK_W-1:0] = mask_reg;

        open_word                  = `LFS_DATA_ZERO;
        open_word[`LFS_DRV_N-1:0]  = lamp_open_reg;
    end

    // ======================================================================
    // Read data, captured before any clear takes effect
    always @* begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            case (reg_addr)
                `LFS_ADDR_MASK: begin
                    rdata_next = mask_word;
                end
                `LFS_ADDR_STAT: begin
                    rdata_next = status_word;
                end
                `LFS_ADDR_OPEN: begin
                    rdata_next = open_word;
                end
                default: begin
                    rdata_next = `LFS_DATA_ZERO;
                end
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            rdata_reg <= `LFS_DATA_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ======================================================================
    // Fault pin; busy and grade bits never take part
    assign fault_any =
        (serial_sum           & ~mask_serial_error)     |
        (trace_sum            & ~mask_trace_break)      |
        (lamp_open_summary    & ~mask_lamp_open)        |
        (lamp_shorted_summary & ~mask_lamp_shorted)     |
        (pump_nrdy            & ~mask_pump_not_ready)   |
        (warn_reg             & ~mask_overtemp_warning) |
        shdn_reg                                        |
        (ext_sel & ext_slow);

    always @(posedge ref_clk) begin
        if (rst) begin
            fault_n_reg <= 1'b1;
        end else begin
            fault_n_reg <= ~fault_any;
        end
    end

    // ======================================================================
    // Thermal shutdown switch action
    always @(posedge ref_clk) begin
        if (rst) begin
            close_reg <= 1'b0;
            open_reg  <= 1'b0;
        end else begin
            close_reg <= shdn_reg & ~overtemp_switch_action;
            open_reg  <= shdn_reg &  overtemp_switch_action;
        end
    end

    // ======================================================================
    // Outputs
    assign reg_rdata          = rdata_reg;
    assign serial_err_flags   = serial_err_reg;
    assign rating_grade_code  = grade_reg;
    assign grade_read_pending = grade_pend_reg;
    assign config_pending     = config_reg;
    assign switch_close_all   = close_reg;
    assign switch_open_all    = open_reg;
    assign fault_flag_n       = fault_n_reg;

endmodule // lfs_fault_status

// ==== hdl/lfs_consts.vh ====
// Purpose: Shared constants of the LED fault status and mask block
// Assumes: Included by every design file of the block
// Notes:   Definitions only
`ifndef LFS_CONSTS_VH
`define LFS_CONSTS_VH

// ==========================================================================
// Register port
`define LFS_DATA_W        13
`define LFS_ADDR_W        8
`define LFS_ADDR_MASK     8'h04
`define LFS_ADDR_STAT     8'h05
`define LFS_ADDR_OPEN     8'h06
`define LFS_DATA_ZERO     13'h0000

// ==========================================================================
// Mask register layout
`define LFS_MASK_W        7
`define LFS_MASK_RST      7'h00
`define LFS_MSK_WARN      0
`define LFS_MSK_ACTION    1
`define LFS_MSK_PUMP      2
`define LFS_MSK_SHORT     3
`define LFS_MSK_OPEN      4
`define LFS_MSK_TRACE     5
`define LFS_MSK_SERIAL    6

// ==========================================================================
// General status layout
`define LFS_ST_WARN       0
`define LFS_ST_SHDN       1
`define LFS_ST_PUMP       2
`define LFS_ST_SHORT      3
`define LFS_ST_OPEN       4
`define LFS_ST_TRACE      5
`define LFS_ST_SERIAL     6
`define LFS_ST_EXTCLK     7
`define LFS_ST_GRADE      8
`define LFS_ST_CONFIG     9

// ==========================================================================
// Widths and reset values
`define LFS_DRV_N         12
`define LFS_DRV_ZERO      12'h000
`define LFS_SER_N         4
`define LFS_SER_ZERO      4'h0
`define LFS_GRADE_W       3
`define LFS_GRADE_RST     3'h0
`define LFS_SEL_W         2
`define LFS_SEL_EXT_BIT   1

// ==========================================================================
// Timing
`define LFS_CLK_PERIOD_NS 8
`define LFS_EXT_MAX_PER_NS 100000
`define LFS_MON_CNT_W     20
`define LFS_MON_CNT_ZERO  20'h0_0000
`define LFS_MON_CNT_ONE   20'h0_0001

`endif

// ==== hdl/lfs_sync.v ====
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs are asynchronous to ref_clk
// Notes:   Output changes once stages two and three agree
`timescale 1ns/100ps
`include "lfs_consts.vh"

module lfs_sync #(
    parameter W = 1
) (
    input  wire         ref_clk,
    input  wire         rst,
    input  wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1_reg;
            reg s2_reg;
            reg s3_reg;
            reg q_reg;
            always @(posedge ref_clk) begin
                if (rst) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    q_reg  <= 1'b0;
                end else begin
                    s1_reg <= d_in[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        q_reg <= s3_reg;
                    end
                end
            end
            assign q_out[i] = q_reg;
        end
    endgenerate

endmodule // lfs_sync

// ==== hdl/lfs_clk_monitor.v ====
// Purpose: Flags an external dimming clock slower than a limit
// Assumes: clk_level is already synchronised to ref_clk
// Notes:   Limit is a count of ref_clk cycles between rising edges
`timescale 1ns/100ps
`include "lfs_consts.vh"

module lfs_clk_monitor #(
    parameter [`LFS_MON_CNT_W-1:0] LIMIT = 20'h0_30D4
) (
    input  wire ref_clk,
    input  wire rst,
    input  wire enable,
    input  wire clk_level,
    output wire slow
);

    reg                      prev_reg;
    reg [`LFS_MON_CNT_W-1:0] cnt_reg;
    reg                      slow_reg;
    wire                     rise;

    assign rise = clk_level & ~prev_reg;

    always @(posedge ref_clk) begin
        if (rst) begin
            prev_reg <= 1'b0;
            cnt_reg  <= `LFS_MON_CNT_ZERO;
            slow_reg <= 1'b0;
        end else begin
            prev_reg <= clk_level;
            if (!enable) begin
                cnt_reg  <= `LFS_MON_CNT_ZERO;
                slow_reg <= 1'b0;
            end else if (rise) begin
                cnt_reg  <= `LFS_MON_CNT_ZERO;
                slow_reg <= (cnt_reg >= LIMIT);
            end else if (cnt_reg < LIMIT) begin
                cnt_reg  <= cnt_reg + `LFS_MON_CNT_ONE;
            end else begin
                slow_reg <= 1'b1;
            end
        end
    end

    assign slow = slow_reg;

endmodule // lfs_clk_monitor

// ==== verification/lfs_fault_status_props.sv ====
// Purpose: Port checker for the fault status block
// Assumes: Mask is tracked from register writes
// Notes:   Bound to lfs_fault_status by the bind below
`timescale 1ns/100ps

module lfs_fault_status_props (
    input wire        ref_clk,
    input wire        rst,
    input wire [7:0]  reg_addr,
    input wire        reg_wr,
    input wire [12:0] reg_wdata,
    input wire [3:0]  serial_err_event,
    input wire        serial_status_rd,
    input wire [3:0]  serial_err_flags,
    input wire [11:0] per_driver_trace_break,
    input wire [11:0] lamp_open_detect,
    input wire        general_config_write,
    input wire        config_applied,
    input wire        grade_done,
    input wire        grade_read_pending,
    input wire        config_pending,
    input wire        switch_close_all,
    input wire        switch_open_all,
    input wire        fault_flag_n
);
    reg [6:0] mask_reg;
    always @(posedge ref_clk) begin
        if (rst)
            mask_reg <= 7'h00;
        else if (reg_wr && reg_addr == 8'h04)
            mask_reg <= reg_wdata[6:0];
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ====================
    // Fault gating and flags
    a_serial_gate: assert property (
        (|serial_err_flags && !mask_reg[6])[*2] |-> !fault_flag_n)
        else $error("serial error not on fault pin");
    a_trace_gate: assert property (
        (|per_driver_trace_break && !mask_reg[5])[*3] |-> !fault_flag_n)
        else $error("trace break not on fault pin");
    a_open_gate: assert property (
        (|lamp_open_detect && !mask_reg[4]) ##1 !mask_reg[4]
        |-> ##1 !fault_flag_n)
        else $error("open lamp not on fault pin");
    a_serial_set: assert property (|serial_err_event |=>
        (serial_err_flags & $past(serial_err_event)) ==
        $past(serial_err_event))
        else $error("serial flag not set");
    a_serial_clear: assert property (
        serial_status_rd && !(|serial_err_event) |=> serial_err_flags == 0)
        else $error("serial flags not cleared");
    a_config_busy: assert property (
        general_config_write |=> config_pending)
        else $error("config busy not set");
    a_config_done: assert property (
        config_applied && !general_config_write |=> !config_pending)
        else $error("config busy not cleared");
    a_grade_ready: assert property (
        grade_done |=> !grade_read_pending)
        else $error("grade still pending");
    a_switch_open: assert property (switch_open_all |->
        !switch_close_all && $past(mask_reg[1]))
        else $error("switches opened with action clear");
    a_switch_close: assert property (
        switch_close_all |-> !$past(mask_reg[1]))
        else $error("switches closed with action set");
    c_open_all: cover property (switch_open_all);
    c_close_all: cover property (switch_close_all);
    c_fault: cover property (!fault_flag_n && mask_reg == 7'h00);
endmodule // lfs_fault_status_props

bind lfs_fault_status lfs_fault_status_props lfs_fault_status_props_i (.*);

// ==== verification/lfs_host_model.sv ====
// Purpose: Host model on the register port
// Assumes: Requests launched at the falling edge
// Notes:   Idle address and data show the inverse of the last value
`timescale 1ns/100ps

module lfs_host_model (
    input  wire        ref_clk,
    input  wire        config_pending,
    input  wire [12:0] reg_rdata,
    output reg  [7:0]  reg_addr = 8'h00,
    output reg         reg_wr = 1'b0,
    output reg         reg_rd = 1'b0,
    output reg  [12:0] reg_wdata = 13'h0000,
    output reg         general_config_write = 1'b0
);
    // ====================
    // Register access
    task wr(input [7:0] a, input [12:0] d);
        begin
            @(negedge ref_clk);
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(negedge ref_clk);
            reg_wr = 1'b0;
            reg_addr = ~a;
            reg_wdata = ~d;
        end
    endtask
    task rd(input [7:0] a, output [12:0] q);
        begin
            @(negedge ref_clk);
            reg_addr = a;
            reg_rd = 1'b1;
            @(negedge ref_clk);
            reg_rd = 1'b0;
            reg_addr = ~a;
            @(negedge ref_clk);
            q = reg_rdata;
        end
    endtask
    // Configuration write waits for the switch engine
    task cfg;
        integer n;
        begin
            n = 0;
            @(negedge ref_clk);
            while (config_pending !== 1'b0 && n < 1000) begin
                @(negedge ref_clk);
                n = n + 1;
            end
            general_config_write = 1'b1;
            @(negedge ref_clk);
            general_config_write = 1'b0;
        end
    endtask
endmodule // lfs_host_model

// ==== verification/lfs_fault_status_test.sv ====
// Purpose: Self-checking bench of the fault status block
// Assumes: Inputs change at the falling edge
// Notes:   Slow clock limit shortened to 100 cycles
`timescale 1ns/100ps

module lfs_fault_status_test;
    reg         ref_clk, rst, serial_status_rd, pump_not_ready_pin;
    reg  [3:0]  serial_err_event;
    reg  [11:0] per_driver_trace_break, per_driver_lamp_shorted;
    reg  [11:0] lamp_open_detect;
    reg         overtemp_shutdown_pin, overtemp_warning_pin;
    reg         dimming_clk_pin, drun, config_applied, grade_done;
    reg  [1:0]  clk_sel;
    reg  [2:0]  grade_code_in;
    wire [7:0]  reg_addr;
    wire        reg_wr, reg_rd, general_config_write;
    wire [12:0] reg_wdata, reg_rdata;
    wire [3:0]  serial_err_flags;
    wire [2:0]  rating_grade_code;
    wire        grade_read_pending, config_pending, fault_flag_n;
    wire        switch_close_all, switch_open_all;
    reg  [12:0] q;
    integer     n_mismatch, tests_run, i, b;
    integer     cyc = 0;

    lfs_fault_status #(.EXT_MAX_PER_NS(800)) lfs_fault_status_i (.*);
    lfs_host_model lfs_host_model_i (.*);

    // ====================
    // Clocks and timeout
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always #40 if (drun) dimming_clk_pin = ~dimming_clk_pin;
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end
    end

    // ====================
    // Helpers
    task stop_test;
        begin
            $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
            if (n_mismatch == 0 && tests_run > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task chk(input string nm, input [12:0] seen, input [12:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("Error %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task w(input integer n);
        repeat (n) @(negedge ref_clk);
    endtask
    task wr(input [7:0] a, input [12:0] d);
        lfs_host_model_i.wr(a, d);
    endtask
    task rdc(input string nm, input [7:0] a, input [12:0] e);
        begin
            lfs_host_model_i.rd(a, q);
            chk(nm, q, e);
        end
    endtask
    task applied;
        begin
            config_applied = 1'b1;
            w(1);
            config_applied = 1'b0;
            w(1);
        end
    endtask
    task src(input integer s, input v);
        case (s)
            6: serial_err_event = v ? 4'h8 : 4'h0;
            5: per_driver_trace_break = v ? 12'h800 : 12'h000;
            4: lamp_open_detect = v ? 12'h800 : 12'h000;
            3: per_driver_lamp_shorted = v ? 12'h800 : 12'h000;
            2: pump_not_ready_pin = v;
            default: overtemp_warning_pin = v;
        endcase
    endtask

    // ====================
    // Test sequence
    initial begin
        n_mismatch = 0;
        tests_run = 0;
        rst = 1'b1;
        {serial_status_rd, pump_not_ready_pin, overtemp_shutdown_pin} = 3'h0;
        {overtemp_warning_pin, dimming_clk_pin, drun} = 3'h0;
        {config_applied, grade_done, clk_sel, grade_code_in} = 7'h00;
        serial_err_event = 4'h0;
        per_driver_trace_break = 12'h000;
        per_driver_lamp_shorted = 12'h000;
        lamp_open_detect = 12'h000;
        w(4);
        rst = 1'b0;
        chk("fault_reset", fault_flag_n, 13'h0001);
        rdc("mask_reset", 8'h04, 13'h0000);
        rdc("stat_reset", 8'h05, 13'h0100);
        rdc("open_reset", 8'h06, 13'h0000);
        wr(8'h05, 13'h1fff);
        rdc("stat_ro", 8'h05, 13'h0100);
        rdc("unmapped", 8'h07, 13'h0000);
        grade_code_in = 3'h5;
        grade_done = 1'b1;
        w(1);
        grade_done = 1'b0;
        w(1);
        chk("grade", {grade_read_pending, rating_grade_code}, 13'h0005);
        wr(8'h04, 13'h1fff);
        rdc("mask_rw", 8'h04, 13'h007f);
        for (i = 0; i < 6; i = i + 1) begin
            b = (i == 5) ? 0 : 6 - i;
            wr(8'h04, 13'h0001 << b);
            src(b, 1'b1);
            w(1);
            if (b == 6 || b == 4)
                src(b, 1'b0);
            w(8);
            chk("masked", fault_flag_n, 13'h0001);
            rdc("summary", 8'h05, 13'h0001 << b);
            if (b == 6)
                chk("ser_flags", serial_err_flags, 13'h0008);
            wr(8'h04, 13'h0000);
            src(b, 1'b1);
            w(3);
            chk("unmasked", fault_flag_n, 13'h0000);
            src(b, 1'b0);
            w(8);
            if (b == 6) begin
                serial_status_rd = 1'b1;
                w(1);
                serial_status_rd = 1'b0;
                w(1);
                chk("ser_clear", serial_err_flags, 13'h0000);
            end
            if (b == 4)
                rdc("open_flags", 8'h06, 13'h0800);
            if (b == 0)
                rdc("warn_latch", 8'h05, 13'h0001);
            w(3);
            chk("released", fault_flag_n, 13'h0001);
            rdc("cleared", 8'h05, 13'h0000);
        end
        overtemp_shutdown_pin = 1'b1;
        w(8);
        chk("close_all", {switch_open_all, switch_close_all, fault_flag_n},
            13'h0002);
        rdc("shdn", 8'h05, 13'h0002);
        rdc("shdn_held", 8'h05, 13'h0002);
        wr(8'h04, 13'h0002);
        w(2);
        chk("open_all", {switch_open_all, switch_close_all, fault_flag_n},
            13'h0004);
        overtemp_shutdown_pin = 1'b0;
        w(8);
        rdc("shdn_latch", 8'h05, 13'h0002);
        w(2);
        chk("shdn_gone", {switch_open_all, switch_close_all, fault_flag_n},
            13'h0001);
        rdc("shdn_clear", 8'h05, 13'h0000);
        lfs_host_model_i.cfg;
        w(1);
        chk("cfg_busy", {config_pending, fault_flag_n}, 13'h0003);
        rdc("cfg_stat", 8'h05, 13'h0200);
        fork
            lfs_host_model_i.cfg;
            begin
                w(5);
                applied;
            end
        join
        chk("cfg_again", config_pending, 13'h0001);
        applied;
        chk("cfg_done", config_pending, 13'h0000);
        for (i = 0; i < 4; i = i + 1) begin
            clk_sel = i;
            drun = 1'b1;
            w(150);
            rdc("ext_run", 8'h05, 13'h0000);
            drun = 1'b0;
            w(150);
            rdc("ext_stop", 8'h05, (i > 1) ? 13'h0080 : 13'h0000);
            if (i > 1)
                chk("ext_fault", fault_flag_n, 13'h0000);
        end
        stop_test;
    end
endmodule // lfs_fault_status_test
